// ==== core/sula_alu.sv ====
// Contract
// - Dual halfword subtract, lanes independent
// - Halfword differences shifted right one bit
// - Quad byte subtract, lanes independent
// - Byte differences halved, written unsigned
// - Add-sub exchange: top is (a.hi+b.lo)/2
// - Add-sub exchange: bottom is (a.lo-b.hi)/2
// - Sub-add exchange: top is (a.hi-b.lo)/2
// - Sub-add exchange: bottom is (b.hi+a.lo)/2
// - Plain halfword subtract, unsigned lane results
// - Plain byte subtract, unsigned byte results
// - Select picks bytes by compare flags
// - Sum absolute byte differences into result
// - Accumulate variant adds third register
// - No status or compare flags modified
// - False predicate leaves destination unwritten
// - Missing destination writes first operand register
`timescale 1ns/100ps
`default_nettype none

`include "sula_defines.svh"

// Packed unsigned lane ALU with one registered write-back
module sula_alu (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic clk_en,
  // Issued instruction
  input wire sula_pkg::sula_issue_type issue,
  // Write-back to register file
  output sula_pkg::sula_wb_type wb,
  // Issuer named a forbidden register
  output logic bad_reg
);
  import sula_pkg::*;

  logic [31:0] a; // First operand
  logic [31:0] b; // Second operand
  logic [31:0] hsub16; // Halved halfword difference
  logic [31:0] hsub8; // Halved byte difference
  logic [31:0] sub16; // Wrapped halfword difference
  logic [31:0] sub8; // Wrapped byte difference
  logic [31:0] sad; // Absolute difference sum
  logic [31:0] sada; // Same plus accumulator
  logic [16:0] ex_sum; // Exchange sum, carry kept
  logic [16:0] ex_dif; // Exchange difference, borrow kept
  logic [31:0] result; // Selected result
  logic known_op; // Opcode is implemented
  logic [3:0] dest; // Resolved destination index

  sula_wb_type wb_reg; // Registered write-back
  sula_wb_type wb_next; // Next write-back
  logic bad_reg_reg; // Registered forbidden-register flag
  logic bad_reg_next; // Next forbidden-register flag

  assign a = issue.first_operand_reg;
  assign b = issue.second_operand_reg;

  // Lane subtracts for both widths
  sula_lane_sub u_lane_sub (
    .a(a),
    .b(b),
    .hsub16(hsub16),
    .hsub8(hsub8),
    .sub16(sub16),
    .sub8(sub8)
  );

  // Absolute difference sums
  sula_sad u_sad (
    .a(a),
    .b(b),
    .acc(issue.accum_value_reg),
    .sad(sad),
    .sada(sada)
  );

  // Forbidden register check
  function automatic logic is_banned(input logic [3:0] idx);
    is_banned = (idx == `SULA_IDX_SP) || (idx == `SULA_IDX_PC);
  endfunction

  // Result select
  always_comb begin
    ex_sum = 17'h00000;
    ex_dif = 17'h00000;
    result = `SULA_ZERO_WORD;
    known_op = 1'b1;
    case (issue.op)
      SULA_HALVING_SUB_DUAL_HALF: begin
        result = hsub16;
      end
      SULA_HALVING_SUB_QUAD_BYTE: begin
        result = hsub8;
      end
      SULA_HALVING_ADD_SUB_EXCHANGE: begin
        ex_sum = {1'b0, a[31:16]} + {1'b0, b[15:0]};
        ex_dif = {1'b0, a[15:0]} - {1'b0, b[31:16]};
        result = {ex_sum[16:1], ex_dif[16:1]};
      end
      SULA_HALVING_SUB_ADD_EXCHANGE: begin
        ex_dif = {1'b0, a[31:16]} - {1'b0, b[15:0]};
        ex_sum = {1'b0, b[31:16]} + {1'b0, a[15:0]};
        result = {ex_dif[16:1], ex_sum[16:1]};
      end
      SULA_PLAIN_SUB_DUAL_HALF: begin
        result = sub16;
      end
      SULA_PLAIN_SUB_QUAD_BYTE: begin
        result = sub8;
      end
      SULA_BYTE_SELECT: begin
        // One picks first operand byte, zero the second
        for (int i = 0; i < 4; i++) begin
          result[i*8 +: 8] = issue.lane_compare_flags[i] ? a[i*8 +: 8] : b[i*8 +: 8];
        end
      end
      SULA_ABS_DIFF_SUM_OP: begin
        result = sad;
      end
      SULA_ABS_DIFF_SUM_ACCUM_OP: begin
        result = sada;
      end
      default: begin
        known_op = 1'b0;
      end
    endcase
  end

  // Destination resolve and write-back decision
  always_comb begin
    dest = issue.dest_given ? issue.dest_idx : issue.first_idx;
    wb_next.wr_en = issue.valid && known_op && issue.cond_pass;
    wb_next.wr_idx = dest;
    wb_next.wr_data = result;
    // Select is exempt from the register limits
    bad_reg_next = issue.valid && known_op && (issue.op != SULA_BYTE_SELECT)
      && (is_banned(dest) || is_banned(issue.first_idx));
  end

  // Output registers; no status flag outputs, only the bad_reg flag
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      wb_reg.wr_en <= 1'b0;
      wb_reg.wr_idx <= `SULA_ZERO_IDX;
      wb_reg.wr_data <= `SULA_ZERO_WORD;
      bad_reg_reg <= 1'b0;
    end else if (clk_en) begin
      wb_reg <= wb_next;
      bad_reg_reg <= bad_reg_next;
    end
  end

  assign wb = wb_reg;
  assign bad_reg = bad_reg_reg;

endmodule

`default_nettype wire

// ==== core/sula_defines.svh ====
`ifndef SULA_DEFINES_SVH
`define SULA_DEFINES_SVH

// Word and lane geometry
`define SULA_WORD_W 32
`define SULA_HALF_W 16
`define SULA_BYTE_W 8
`define SULA_REG_IDX_W 4
`define SULA_OP_W 4

// Operation codes
`define SULA_OP_NOP 4'h0
`define SULA_OP_HSUB16 4'h1
`define SULA_OP_HSUB8 4'h2
`define SULA_OP_HASX 4'h3
`define SULA_OP_HSAX 4'h4
`define SULA_OP_SUB16 4'h5
`define SULA_OP_SUB8 4'h6
`define SULA_OP_SEL 4'h7
`define SULA_OP_SAD 4'h8
`define SULA_OP_SADA 4'h9

// Register indices the issuer must avoid
`define SULA_IDX_SP 4'hD
`define SULA_IDX_PC 4'hF

// Reset values
`define SULA_ZERO_WORD 32'h0000_0000
`define SULA_ZERO_IDX 4'h0

`endif

// ==== core/sula_pkg.sv ====
`default_nettype none

`include "sula_defines.svh"

package sula_pkg;

  // Operation selector
  typedef enum logic [3:0] {
    SULA_NOP = 4'h0,
    SULA_HALVING_SUB_DUAL_HALF = 4'h1,
    SULA_HALVING_SUB_QUAD_BYTE = 4'h2,
    SULA_HALVING_ADD_SUB_EXCHANGE = 4'h3,
    SULA_HALVING_SUB_ADD_EXCHANGE = 4'h4,
    SULA_PLAIN_SUB_DUAL_HALF = 4'h5,
    SULA_PLAIN_SUB_QUAD_BYTE = 4'h6,
    SULA_BYTE_SELECT = 4'h7,
    SULA_ABS_DIFF_SUM_OP = 4'h8,
    SULA_ABS_DIFF_SUM_ACCUM_OP = 4'h9
  } sula_op_type;

  // One issued instruction
  typedef struct packed {
    logic valid;
    sula_op_type op;
    logic cond_pass;
    logic dest_given;
    logic [3:0] dest_idx;
    logic [3:0] first_idx;
    logic [31:0] first_operand_reg;
    logic [31:0] second_operand_reg;
    logic [31:0] accum_value_reg;
    logic [3:0] lane_compare_flags;
  } sula_issue_type;

  // One write-back
  typedef struct packed {
    logic wr_en;
    logic [3:0] wr_idx;
    logic [31:0] wr_data;
  } sula_wb_type;

endpackage

`default_nettype wire

// ==== core/sula_lane_sub.sv ====
`timescale 1ns/100ps
`default_nettype none

// Lane subtract/halving unit for both lane widths
module sula_lane_sub (
  // Operands
  input wire logic [31:0] a,
  input wire logic [31:0] b,
  // Results
  output logic [31:0] hsub16,
  output logic [31:0] hsub8,
  output logic [31:0] sub16,
  output logic [31:0] sub8
);

  // Halfword difference with borrow kept in bit 16
  function automatic logic [16:0] diff17(input logic [15:0] x, input logic [15:0] y);
    diff17 = {1'b0, x} - {1'b0, y};
  endfunction

  // Byte difference with borrow kept in bit 8
  function automatic logic [8:0] diff9(input logic [7:0] x, input logic [7:0] y);
    diff9 = {1'b0, x} - {1'b0, y};
  endfunction

  logic [16:0] d16_lo; // Low halfword difference
  logic [16:0] d16_hi; // High halfword difference
  logic [8:0] d8 [4]; // Byte differences

  // Lane arithmetic
  always_comb begin
    d16_lo = diff17(a[15:0], b[15:0]);
    d16_hi = diff17(a[31:16], b[31:16]);
    for (int i = 0; i < 4; i++) begin
      d8[i] = diff9(a[i*8 +: 8], b[i*8 +: 8]);
    end
    // Halve from the full 17-bit result
    hsub16 = {d16_hi[16:1], d16_lo[16:1]};
    // Plain result wraps to the lane
    sub16 = {d16_hi[15:0], d16_lo[15:0]};
    for (int i = 0; i < 4; i++) begin
      hsub8[i*8 +: 8] = d8[i][8:1];
      sub8[i*8 +: 8] = d8[i][7:0];
    end
  end

endmodule

`default_nettype wire

// ==== core/sula_sad.sv ====
`timescale 1ns/100ps
`default_nettype none

// Sum of absolute byte differences, optional accumulate
module sula_sad (
  // Operands
  input wire logic [31:0] a,
  input wire logic [31:0] b,
  input wire logic [31:0] acc,
  // Results
  output logic [31:0] sad,
  output logic [31:0] sada
);

  // Absolute byte difference
  function automatic logic [7:0] absdiff(input logic [7:0] x, input logic [7:0] y);
    absdiff = (x >= y) ? (x - y) : (y - x);
  endfunction

  logic [9:0] total; // Up to 4 x 255

  // Add the four magnitudes
  always_comb begin
    total = 10'h000;
    for (int i = 0; i < 4; i++) begin
      total = total + {2'h0, absdiff(a[i*8 +: 8], b[i*8 +: 8])};
    end
    sad = {22'h000000, total};
    sada = acc + {22'h000000, total};
  end

endmodule

`default_nettype wire

// ==== bench/sula_alu_asserts.sv ====
`timescale 1ns/100ps
`default_nettype none
// Port-level checks on the lane ALU
module sula_alu_asserts (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic clk_en,
  // Issue and results
  input wire sula_pkg::sula_issue_type issue,
  input wire sula_pkg::sula_wb_type wb,
  input wire logic bad_reg
);
  import sula_pkg::*;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!nrst);
  // Enabled, present and predicated true
  logic go;
  // Full-precision low halfword difference
  logic [16:0] hd;
  // Wrapped low byte difference
  logic [7:0] bd;
  assign go = clk_en && issue.valid && issue.cond_pass;
  assign hd = {1'b0, issue.first_operand_reg[15:0]} - {1'b0, issue.second_operand_reg[15:0]};
  assign bd = issue.first_operand_reg[7:0] - issue.second_operand_reg[7:0];
  half_halve_a: assert property (go && issue.op == SULA_HALVING_SUB_DUAL_HALF |=>
    wb.wr_data[15:0] == $past(hd[16:1])) else $error("halved halfword wrong");
  byte_wrap_a: assert property (go && issue.op == SULA_PLAIN_SUB_QUAD_BYTE |=>
    wb.wr_data[7:0] == $past(bd)) else $error("wrapped byte wrong");
  sel_pick_a: assert property (go && issue.op == SULA_BYTE_SELECT |=> wb.wr_data[7:0] ==
    ($past(issue.lane_compare_flags[0]) ? $past(issue.first_operand_reg[7:0])
    : $past(issue.second_operand_reg[7:0]))) else $error("select byte wrong");
  pred_off_a: assert property (clk_en && !issue.cond_pass |=> !wb.wr_en)
    else $error("write despite false predicate");
  dest_omit_a: assert property (go && !issue.dest_given |=>
    wb.wr_idx == $past(issue.first_idx)) else $error("omitted destination wrong");
  dest_given_a: assert property (go && issue.dest_given |=>
    wb.wr_idx == $past(issue.dest_idx)) else $error("given destination wrong");
  bad_name_a: assert property (go && issue.op == SULA_PLAIN_SUB_DUAL_HALF &&
    issue.first_idx == 4'hD |=> bad_reg) else $error("forbidden index missed");
  sel_free_a: assert property (clk_en && issue.op == SULA_BYTE_SELECT |=> !bad_reg)
    else $error("select flagged");
  op_unknown_a: assert property (clk_en && issue.valid &&
    issue.op > SULA_ABS_DIFF_SUM_ACCUM_OP |=> !wb.wr_en && !bad_reg)
    else $error("unknown opcode wrote");
  freeze_out_a: assert property (!clk_en |=> $stable(wb) && $stable(bad_reg))
    else $error("outputs moved while frozen");
endmodule
bind sula_alu sula_alu_asserts chk_u (.sys_clk(sys_clk), .nrst(nrst), .clk_en(clk_en),
  .issue(issue), .wb(wb), .bad_reg(bad_reg));
`default_nettype wire

// ==== bench/sula_issuer.sv ====
`timescale 1ns/100ps
`default_nettype none
// Decoder and register file side: presents instructions
module sula_issuer (
  // Clock
  input wire logic sys_clk,
  // Issued instruction
  output var sula_pkg::sula_issue_type issue
);
  import sula_pkg::*;
  // Nothing issued at start
  initial issue = '0;
  // Present one instruction just after a falling edge
  task automatic put(input sula_op_type op, input logic [31:0] a, b, c, input logic [3:0] fl,
    input logic cp, dg, input logic [3:0] dx, fx);
    @(negedge sys_clk);
    issue <= '{1'b1, op, cp, dg, dx, fx, a, b, c, fl};
  endtask
  // Withdraw; first operand scrambled so stale data cannot pass
  task automatic idle;
    @(negedge sys_clk);
    issue.valid <= 1'b0;
    issue.first_operand_reg <= ~issue.first_operand_reg;
  endtask
endmodule
`default_nettype wire

// ==== bench/simd_unsigned_lane_alu_test.sv ====
`timescale 1ns/100ps
`default_nettype none
// Self-checking bench for the lane ALU
module simd_unsigned_lane_alu_test;
  import sula_pkg::*;
  // Operands and results per op 1..9
  localparam logic [31:0] A = 32'h8003_10FF;
  localparam logic [31:0] B = 32'h0004_2001;
  localparam logic [31:0] C = 32'hFFFF_FFF0;
  localparam logic [31:0] EXP [9] = '{32'h3FFF_F87F, 32'h40FF_F87F, 32'h5002_087D,
    32'h3001_0881, 32'h7FFF_F0FE, 32'h80FF_F0FE, 32'h0003_20FF, 32'h0000_018F, 32'h0000_017F};
  // Design ports
  logic sys_clk = 1'b0;
  logic nrst = 1'b0;
  logic clk_en = 1'b1;
  sula_issue_type issue;
  sula_wb_type wb;
  logic bad_reg;
  // Counters
  int fails = 0;
  int cmp_count = 0;
  sula_alu dut_u (.sys_clk(sys_clk), .nrst(nrst), .clk_en(clk_en), .issue(issue), .wb(wb),
    .bad_reg(bad_reg));
  sula_issuer src_u (.sys_clk(sys_clk), .issue(issue));
  // 50 MHz clock
  initial begin
    forever #10 sys_clk = ~sys_clk;
  end
  // Compare one value
  task automatic chk(input string nm, input logic [31:0] e, g);
    cmp_count++;
    if (g !== e) begin
      fails++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask
  // Issue one op and let its write-back land
  task automatic go(input sula_op_type op, input logic cp, dg, input logic [3:0] dx, fx);
    src_u.put(op, A, B, C, 4'h5, cp, dg, dx, fx);
    @(posedge sys_clk);
    #1;
  endtask
  // Every op 1..9 back to back
  task automatic t_ops;
    for (int i = 0; i < 9; i++) begin
      go(sula_op_type'(i + 1), 1'b1, 1'b1, 4'(i), 4'h1);
      chk("wr_en", 32'h1, wb.wr_en);
      chk("wr_idx", 32'(i), wb.wr_idx);
      chk("wr_data", EXP[i], wb.wr_data);
    end
  endtask
  // False predicate, no-op, then a frozen cycle
  task automatic t_pred;
    go(SULA_PLAIN_SUB_QUAD_BYTE, 1'b0, 1'b1, 4'h2, 4'h1);
    chk("pred_off", 32'h0, wb.wr_en);
    go(SULA_NOP, 1'b1, 1'b1, 4'h2, 4'h1);
    chk("nop", 32'h0, wb.wr_en);
    // Undecoded opcode with a forbidden index: no write, no flag
    go(sula_op_type'(4'hA), 1'b1, 1'b0, 4'h0, 4'hD);
    chk("unknown", 32'h0, wb.wr_en);
    chk("unknown_bad", 32'h0, bad_reg);
    go(SULA_PLAIN_SUB_QUAD_BYTE, 1'b1, 1'b1, 4'h2, 4'h1);
    src_u.idle();
    clk_en = 1'b0;
    @(posedge sys_clk);
    #1;
    chk("frozen", EXP[5], wb.wr_data);
    chk("frozen_en", 32'h1, wb.wr_en);
    @(negedge sys_clk);
    clk_en = 1'b1;
    @(posedge sys_clk);
    #1;
    chk("idle", 32'h0, wb.wr_en);
  endtask
  // Omitted destination goes to first operand register
  task automatic t_dest;
    go(SULA_ABS_DIFF_SUM_OP, 1'b1, 1'b0, 4'h9, 4'h3);
    chk("omit_idx", 32'h3, wb.wr_idx);
    chk("sad", EXP[7], wb.wr_data);
  endtask
  // Forbidden index flagged except for select
  task automatic t_bad;
    go(SULA_PLAIN_SUB_DUAL_HALF, 1'b1, 1'b0, 4'h0, 4'hD);
    chk("bad", 32'h1, bad_reg);
    go(SULA_BYTE_SELECT, 1'b1, 1'b1, 4'hF, 4'hD);
    chk("sel_ok", 32'h0, bad_reg);
    chk("sel_idx", 32'hF, wb.wr_idx);
  endtask
  // Mid-run reset clears outputs; first edge after release takes the held op
  task automatic t_rst;
    @(negedge sys_clk);
    nrst = 1'b0;
    @(posedge sys_clk);
    #1;
    chk("rst_en", 32'h0, wb.wr_en);
    chk("rst_idx", 32'h0, wb.wr_idx);
    chk("rst_data", 32'h0, wb.wr_data);
    chk("rst_bad", 32'h0, bad_reg);
    @(negedge sys_clk);
    nrst = 1'b1;
    @(posedge sys_clk);
    #1;
    chk("rel_data", EXP[6], wb.wr_data);
    chk("rel_idx", 32'hF, wb.wr_idx);
    go(SULA_HALVING_SUB_QUAD_BYTE, 1'b1, 1'b1, 4'h4, 4'h1);
    chk("rel_hsub8", EXP[1], wb.wr_data);
    chk("rel_hidx", 32'h4, wb.wr_idx);
  endtask
  // Verdict and end
  task automatic print_verdict;
    if (fails == 0 && cmp_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  // Main sequence
  initial begin
    repeat (10) @(posedge sys_clk);
    @(negedge sys_clk);
    nrst = 1'b1;
    t_ops();
    t_pred();
    t_dest();
    t_bad();
    t_rst();
    print_verdict();
  end
  // Watchdog
  initial begin
    repeat (2000) @(posedge sys_clk);
    fails++;
    print_verdict();
  end
endmodule
`default_nettype wire
